//--- mft_pkg.sv
// mft_pkg: shared types and constants for the multifunction pin router
// assumes: one clock domain, pin-level functions produced elsewhere
package mft_pkg;

    localparam int unsigned mft_sel_w = 4;

    // function select codes for one multifunction pin
    typedef enum logic [3:0] {
        mft_fn_irq_line = 4'h0,
        mft_fn_pci_irq = 4'h1,
        mft_fn_gen_in = 4'h2,
        mft_fn_gen_out = 4'h3,
        mft_fn_led = 4'h4,
        mft_fn_zv = 4'h5,
        mft_fn_audio = 4'h6,
        mft_fn_gpe = 4'h7,
        mft_fn_ring = 4'h8,
        mft_fn_deep_pwr = 4'h9,
        mft_fn_serial_irq = 4'ha,
        mft_fn_lock = 4'hb,
        mft_fn_clkrun = 4'hc
    } mft_func_type;

    // selector reset value: pin 3 comes up in its serial interrupt function, pin 6 in clkrun
    localparam logic [3:0] mft_sel_rst_pin3 = 4'ha;
    localparam logic [3:0] mft_sel_rst_other = 4'h0;

    // one pin: output, output enable
    typedef struct packed {
        logic drive;
        logic oe;
    } mft_pin_out_type;

    // signals that a pin may carry, as produced by the rest of the bridge
    typedef struct packed {
        logic pci_irq_a;
        logic pci_irq_b;
        logic led;
        logic zoomed_video;
        logic audio_pwm;
        logic general_purpose_event;
        logic ring_pme;
        logic deep_power_state_status;
        logic lock_out;
        logic lock_oe;
        logic clkrun_out;
        logic clkrun_oe;
        logic serialized_interrupt_out;
        logic serialized_interrupt_oe;
        logic sda_out;
        logic sda_oe;
        logic scl_out;
        logic scl_oe;
    } mft_src_type;

    // load sequence states
    typedef enum logic [2:0] {
        mft_st_idle = 3'b001,
        mft_st_load = 3'b010,
        mft_st_done = 3'b100
    } mft_state_type;

endpackage

//--- mft_pin_cell.sv
// mft_pin_cell: output mux and enable for one multifunction pin
// assumes: select and sources registered in the sys_clk domain
`timescale 1ns/1ns
`default_nettype none
module mft_pin_cell
    import mft_pkg::*;
#(
    parameter logic [12:0] ALLOWED = 13'h1fff,
    parameter int unsigned IDX = 0
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // selection and sources
    input wire logic [3:0] sel,
    input wire mft_src_type src,
    input wire logic gen_out,
    input wire logic irq_line,
    // pin
    output mft_pin_out_type pin
);

    mft_pin_out_type pin_next;
    mft_pin_out_type pin_reg;

    always_comb
    begin
        pin_next = '0;
        if ((32'(sel) < $bits(ALLOWED)) && ALLOWED[sel])
        begin
            case (mft_func_type'(sel))
                mft_fn_irq_line:
                begin
                    pin_next.drive = irq_line;
                    pin_next.oe = 1'b1;
                end
                mft_fn_pci_irq:
                begin
                    pin_next.drive = 1'b0;
                    pin_next.oe = (IDX == 0) ? src.pci_irq_a : src.pci_irq_b;
                end
                mft_fn_gen_in: pin_next = '0;
                mft_fn_gen_out: pin_next = '{gen_out, 1'b1};
                mft_fn_led: pin_next = '{src.led, 1'b1};
                mft_fn_zv: pin_next = '{src.zoomed_video, 1'b1};
                mft_fn_audio: pin_next = '{src.audio_pwm, 1'b1};
                mft_fn_gpe: pin_next = '{src.general_purpose_event, 1'b1};
                mft_fn_ring: pin_next = '{src.ring_pme, 1'b1};
                mft_fn_deep_pwr:
                    pin_next = '{src.deep_power_state_status, 1'b1};
                mft_fn_serial_irq: pin_next = '{src.serialized_interrupt_out,
                    src.serialized_interrupt_oe};
                mft_fn_lock: pin_next = '{src.lock_out, src.lock_oe};
                mft_fn_clkrun: pin_next = '{src.clkrun_out, src.clkrun_oe};
                default: pin_next = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            pin_reg <= '0;
        else
            pin_reg <= pin_next;
    end

    assign pin = pin_reg;

endmodule
`default_nettype wire

//--- mft_router.sv
// mft_router: multifunction pin routing, serial-bus strap, speaker, ring
// assumes: all pins enter through two flip-flops; rest on sys_clk
`timescale 1ns/1ns
`default_nettype none
module mft_router
    import mft_pkg::*;
#(
    parameter int unsigned SLOTS = 2
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // external reset and strap pins
    input wire logic global_reset_n,
    input wire logic pci_reset_n,
    input wire logic serial_strap,
    input wire logic suspend_n,
    // routing selects, pins 0..6
    input wire logic [27:0] route_sel,
    input wire logic [4:0] general_output,
    input wire logic [6:0] irq_line,
    input wire mft_src_type src,
    // ring indicate source choice
    input wire logic ring_sel_pme,
    input wire logic ring_indicate,
    input wire logic power_event,
    // card audio
    input wire logic [SLOTS-1:0] card_speaker_input,
    input wire logic [SLOTS-1:0] card_audio_input,
    // pin inputs
    input wire logic [6:0] multi_pin_in,
    // pin outputs
    output logic [6:0] multi_pin_out,
    output logic [6:0] multi_pin_oe,
    output logic [4:0] general_input,
    output logic speaker_output,
    output logic ring_indicate_output,
    // serial bus state
    output logic serial_bus_en,
    output logic eeprom_load_req,
    output logic sda_in,
    output logic regs_clear
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    localparam int unsigned sync_w = 7 + 4 + 2 * SLOTS;
    logic [sync_w-1:0] sync1_reg, sync2_reg, sync1_next, sync2_next;
    logic [6:0] pin_s;
    logic global_reset_s, pci_reset_s, strap_s, susp_s;
    logic [SLOTS-1:0] spk_s, aud_s;

    always_comb
    begin
        sync1_next = {multi_pin_in, global_reset_n, pci_reset_n, serial_strap,
            suspend_n, card_speaker_input, card_audio_input};
        sync2_next = sync1_reg;
    end

    always_ff @(posedge sys_clk)
    begin
        sync1_reg <= sync1_next;
        sync2_reg <= sync2_next;
    end

    assign {pin_s, global_reset_s, pci_reset_s, strap_s, susp_s, spk_s, aud_s} = sync2_reg;

    ////////////////////////////////////////////////////////////////////////
    // reset edges, strap capture, suspend protection
    logic global_reset_d_reg, global_reset_d_next, pci_reset_d_reg, pci_reset_d_next;
    logic ser_en_reg, ser_en_next;
    mft_state_type st_reg, st_next;
    logic clear_now;

    assign clear_now = (!global_reset_s || !pci_reset_s) && susp_s;

    always_comb
    begin
        global_reset_d_next = global_reset_s;
        pci_reset_d_next = pci_reset_s;
        ser_en_next = ser_en_reg;
        if (global_reset_s && !global_reset_d_reg)
            ser_en_next = !strap_s;
        st_next = st_reg;
        case (st_reg)
            mft_st_idle:
                if (ser_en_reg && pci_reset_s && !pci_reset_d_reg)
                    st_next = mft_st_load;
            mft_st_load:
                st_next = mft_st_done;
            mft_st_done:
                if (!pci_reset_s)
                    st_next = mft_st_idle;
            default:
                st_next = mft_st_idle;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            global_reset_d_reg <= 1'b1;
            pci_reset_d_reg <= 1'b1;
            ser_en_reg <= 1'b0;
            st_reg <= mft_st_idle;
        end
        else
        begin
            global_reset_d_reg <= global_reset_d_next;
            pci_reset_d_reg <= pci_reset_d_next;
            ser_en_reg <= ser_en_next;
            st_reg <= st_next;
        end
    end

    assign serial_bus_en = ser_en_reg;
    assign eeprom_load_req = (st_reg == mft_st_load);
    assign regs_clear = clear_now;

    ////////////////////////////////////////////////////////////////////////
    // routing select registers, kept while suspended
    logic [27:0] sel_reg, sel_next;
    localparam logic [27:0] sel_rst = {mft_fn_clkrun, mft_sel_rst_other,
        mft_sel_rst_other, mft_sel_rst_pin3, mft_sel_rst_other,
        mft_sel_rst_other, mft_sel_rst_other};

    always_comb
    begin
        if (clear_now)
            sel_next = sel_rst;
        else
            sel_next = route_sel;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            sel_reg <= sel_rst;
        else
            sel_reg <= sel_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // pin cells
    // allowed masks: bit n enables function code n
    localparam logic [12:0] allow0 = 13'h00ff;
    localparam logic [12:0] allow1 = 13'h00ff;
    localparam logic [12:0] allow2 = 13'h03fd;
    localparam logic [12:0] allow3 = 13'h0401;
    localparam logic [12:0] allow4 = 13'h0bfd;
    localparam logic [12:0] allow5 = 13'h02fd;
    localparam logic [12:0] allow6 = 13'h1001;
    localparam logic [90:0] allow_all = {allow6, allow5, allow4, allow3,
        allow2, allow1, allow0};

    mft_pin_out_type cell_out [7];
    logic [2:0] gidx [7];
    assign gidx = '{3'h0, 3'h1, 3'h2, 3'h0, 3'h3, 3'h4, 3'h0};

    genvar g;
    generate
        for (g = 0; g < 7; g++)
        begin : cells
            mft_pin_cell #(
                .ALLOWED(allow_all[13*g +: 13]),
                .IDX(g)
            ) u_cell (
                .sys_clk(sys_clk),
                .rstn(rstn),
                .sel(sel_reg[4*g +: 4]),
                .src(src),
                .gen_out(general_output[gidx[g]]),
                .irq_line(irq_line[g]),
                .pin(cell_out[g])
            );
        end
    endgenerate

    // serial bus overrides pins 1 and 4 while enabled
    always_comb
    begin
        for (int i = 0; i < 7; i++)
        begin
            multi_pin_out[i] = cell_out[i].drive;
            multi_pin_oe[i] = cell_out[i].oe;
        end
        if (ser_en_reg)
        begin
            multi_pin_out[1] = src.sda_out;
            multi_pin_oe[1] = src.sda_oe;
            multi_pin_out[4] = src.scl_out;
            multi_pin_oe[4] = src.scl_oe;
        end
    end

    assign sda_in = pin_s[1];

    ////////////////////////////////////////////////////////////////////////
    // general inputs, speaker, ring output
    logic [4:0] gin_reg, gin_next;
    logic spk_reg, spk_next, ring_reg, ring_next;

    always_comb
    begin
        gin_next = gin_reg;
        if (sel_reg[3:0] == mft_fn_gen_in)
            gin_next[0] = pin_s[0];
        if (sel_reg[7:4] == mft_fn_gen_in && !ser_en_reg)
            gin_next[1] = pin_s[1];
        if (sel_reg[11:8] == mft_fn_gen_in)
            gin_next[2] = pin_s[2];
        if (sel_reg[19:16] == mft_fn_gen_in && !ser_en_reg)
            gin_next[3] = pin_s[4];
        if (sel_reg[23:20] == mft_fn_gen_in)
            gin_next[4] = pin_s[5];
        spk_next = ^{spk_s, aud_s};
        ring_next = ring_sel_pme ? power_event : ring_indicate;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            gin_reg <= '0;
            spk_reg <= 1'b0;
            ring_reg <= 1'b0;
        end
        else
        begin
            gin_reg <= gin_next;
            spk_reg <= spk_next;
            ring_reg <= ring_next;
        end
    end

    assign general_input = gin_reg;
    assign speaker_output = spk_reg;
    assign ring_indicate_output = ring_reg;

endmodule
`default_nettype wire

//--- mft_router_monitor.sv
// mft_router_monitor: port assertions for the pin router
// assumes: bound to mft_router, single sys_clk domain
`timescale 1ns/1ns
`default_nettype none
module mft_router_monitor
    import mft_pkg::*;
#(
    parameter int unsigned SLOTS = 2
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic pci_reset_n,
    input wire logic suspend_n,
    input wire logic [27:0] route_sel,
    input wire logic [4:0] general_output,
    input wire mft_src_type src,
    input wire logic ring_sel_pme,
    input wire logic ring_indicate,
    input wire logic power_event,
    input wire logic [SLOTS-1:0] card_speaker_input,
    input wire logic [SLOTS-1:0] card_audio_input,
    input wire logic [6:0] multi_pin_out,
    input wire logic [6:0] multi_pin_in,
    input wire logic [6:0] multi_pin_oe,
    input wire logic speaker_output,
    input wire logic ring_indicate_output,
    input wire logic serial_bus_en,
    input wire logic sda_in,
    input wire logic eeprom_load_req,
    input wire logic regs_clear
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    a_pin0_genout: assert property (((route_sel[3:0] == 4'h3) &&
        $stable(route_sel) && $stable(general_output))[*3] |->
        multi_pin_oe[0] && multi_pin_out[0] == general_output[0])
        else $error("pin 0 general output wrong");
    a_pin1_sda: assert property ((serial_bus_en && $stable(src))[*3]
        |-> {multi_pin_oe[1], multi_pin_out[1]} == {src.sda_oe, src.sda_out})
        else $error("pin 1 serial data wrong");
    a_input_quiet: assert property ((route_sel[11:8] == 4'h2 &&
        !regs_clear)[*3] |-> !multi_pin_oe[2])
        else $error("input pin driven");
    a_sda_echo: assert property (sda_in == $past(multi_pin_in[1], 2))
        else $error("serial data input wrong");
    a_pin3_default: assert property (regs_clear[*3] |->
        {multi_pin_oe[3], multi_pin_out[3]} ==
        $past({src.serialized_interrupt_oe, src.serialized_interrupt_out}))
        else $error("pin 3 not serial interrupt after reset");
    a_bad_code: assert property ((route_sel[27:24] == 4'h3)[*3]
        |-> !multi_pin_oe[6]) else $error("pin 6 bad code driven");
    a_pin3_serial: assert property (((route_sel[15:12] == 4'ha) &&
        $stable(src))[*3] |-> {multi_pin_oe[3], multi_pin_out[3]} ==
        {src.serialized_interrupt_oe, src.serialized_interrupt_out})
        else $error("pin 3 serial interrupt wrong");
    a_speaker_xor: assert property (($stable(card_speaker_input) &&
        $stable(card_audio_input))[*4] |-> speaker_output ==
        (^card_speaker_input ^ ^card_audio_input))
        else $error("speaker output wrong");
    a_ring_choice: assert property
        ($stable({ring_sel_pme, ring_indicate, power_event})[*4] |->
        ring_indicate_output == (ring_sel_pme ? power_event : ring_indicate))
        else $error("ring output wrong");
    a_load_after: assert property (serial_bus_en && $rose(pci_reset_n)
        |-> ##[1:6] eeprom_load_req) else $error("no eeprom load");
    a_load_pulse: assert property (eeprom_load_req |=>
        !eeprom_load_req) else $error("load request too long");
    a_keep_regs: assert property ((!suspend_n)[*3] |-> !regs_clear)
        else $error("registers cleared in suspend");
    c_load: cover property (eeprom_load_req);
    c_bus: cover property (serial_bus_en && !pci_reset_n);
    c_spk: cover property ($rose(speaker_output));
endmodule
bind mft_router mft_router_monitor #(.SLOTS(SLOTS)) u_mft_router_monitor (
    .sys_clk(sys_clk), .rstn(rstn), .pci_reset_n(pci_reset_n),
    .suspend_n(suspend_n), .route_sel(route_sel),
    .general_output(general_output), .src(src),
    .ring_sel_pme(ring_sel_pme), .ring_indicate(ring_indicate),
    .power_event(power_event), .card_speaker_input(card_speaker_input),
    .card_audio_input(card_audio_input), .multi_pin_out(multi_pin_out),
    .multi_pin_oe(multi_pin_oe), .speaker_output(speaker_output),
    .ring_indicate_output(ring_indicate_output),
    .serial_bus_en(serial_bus_en), .eeprom_load_req(eeprom_load_req),
    .multi_pin_in(multi_pin_in), .sda_in(sda_in),
    .regs_clear(regs_clear));
`default_nettype wire

//--- mft_host_model.sv
// mft_host_model: host side of the multifunction pins
// assumes: host value shows wherever the router does not drive
`timescale 1ns/1ns
`default_nettype none
module mft_host_model
(
    // router side
    input wire logic [6:0] pin_out,
    input wire logic [6:0] pin_oe,
    input wire logic [6:0] host_val,
    // resolved pins
    output logic [6:0] pin_wire
);
    assign pin_wire = (pin_oe & pin_out) | (~pin_oe & host_val);
endmodule
`default_nettype wire

//--- tb_multifunction_terminal_routing.sv
// tb_multifunction_terminal_routing: self-checking router bench
// assumes: mft_router, its monitor and the host model compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_multifunction_terminal_routing;
    import mft_pkg::*;
    logic sys_clk = 1'b0, rstn = 1'b0, global_reset_n = 1'b1;
    logic pci_reset_n = 1'b1, serial_strap = 1'b1, suspend_n = 1'b1;
    logic ring_sel_pme = 1'b0, ring_indicate = 1'b0, power_event = 1'b0;
    logic spk_out, ring_out, bus_en, load_req, sda_in, clr, bus = 1'b0;
    logic [27:0] route_sel = 28'h0;
    logic [4:0] general_output = 5'h0, gin = 5'h0, gen_in;
    logic [6:0] irq_line = 7'h0, host_val = 7'h0, pin_in, pin_out, pin_oe;
    logic [1:0] spk_in = 2'h0, aud_in = 2'h0, loads = 2'h0, lexp = 2'h0;
    mft_src_type src = '0;
    logic [13:0] pin_q[$];
    logic [10:0] misc_q[$];
    int mismatches = 0, n_checks = 0, cyc = 0;
    logic [12:0] ok_tab [0:6] = '{13'h00ff, 13'h00ff, 13'h03fd, 13'h0401,
        13'h0bfd, 13'h02fd, 13'h1001};
    int gi [0:6] = '{0, 1, 2, 0, 3, 4, 0};
    mft_router #(.SLOTS(2)) u_mft_router (.sys_clk(sys_clk), .rstn(rstn),
        .global_reset_n(global_reset_n), .pci_reset_n(pci_reset_n),
        .serial_strap(serial_strap), .suspend_n(suspend_n),
        .route_sel(route_sel), .general_output(general_output),
        .irq_line(irq_line), .src(src), .ring_sel_pme(ring_sel_pme),
        .ring_indicate(ring_indicate), .power_event(power_event),
        .card_speaker_input(spk_in), .card_audio_input(aud_in),
        .multi_pin_in(pin_in), .multi_pin_out(pin_out),
        .multi_pin_oe(pin_oe), .general_input(gen_in),
        .speaker_output(spk_out), .ring_indicate_output(ring_out),
        .serial_bus_en(bus_en), .eeprom_load_req(load_req),
        .sda_in(sda_in), .regs_clear(clr));
    mft_host_model u_mft_host_model (.pin_out(pin_out), .pin_oe(pin_oe),
        .host_val(host_val), .pin_wire(pin_in));
    always #5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [1:0] exp_pin(int p);
        logic [3:0] c;
        c = route_sel[4*p +: 4];
        if (bus && p == 1) return {src.sda_oe, src.sda_out};
        if (bus && p == 4) return {src.scl_oe, src.scl_out};
        if (!ok_tab[p][c]) return 2'b00;
        case (c)
            4'h0: return {1'b1, irq_line[p]};
            4'h1: return {(p == 0 ? src.pci_irq_a : src.pci_irq_b), 1'b0};
            4'h3: return {1'b1, general_output[gi[p]]};
            4'h4: return {1'b1, src.led};
            4'h5: return {1'b1, src.zoomed_video};
            4'h6: return {1'b1, src.audio_pwm};
            4'h7: return {1'b1, src.general_purpose_event};
            4'h8: return {1'b1, src.ring_pme};
            4'h9: return {1'b1, src.deep_power_state_status};
            4'ha: return {src.serialized_interrupt_oe,
                src.serialized_interrupt_out};
            4'hb: return {src.lock_oe, src.lock_out};
            4'hc: return {src.clkrun_oe, src.clkrun_out};
            default: return 2'b00;
        endcase
    endfunction
    task automatic note_pins();
        logic [13:0] e;
        for (int p = 0; p < 7; p++) {e[7+p], e[p]} = exp_pin(p);
        pin_q.push_back(e);
    endtask
    task automatic note_misc(logic c);
        misc_q.push_back({gin, ^{spk_in, aud_in},
            ring_sel_pme ? power_event : ring_indicate, bus, c, lexp});
    endtask
    task automatic tally(logic ok, logic [13:0] e, logic [13:0] a);
        n_checks++;
        if (!ok)
        begin
            mismatches++;
            $display("unexpected at %0t: exp %h got %h", $time, e, a);
        end
    endtask
    task automatic cmp_pins(logic [13:0] e, logic [13:0] a);
        tally(a === e, e, a);
    endtask
    task automatic cmp_misc(logic [10:0] e, logic [10:0] a);
        tally(a === e, {3'h0, e}, {3'h0, a});
    endtask
    task automatic pulse_pci(logic s);
        suspend_n = s;
        pci_reset_n = 1'b0;
        repeat (5) @(negedge sys_clk);
        note_misc(s);
        @(negedge sys_clk);
        pci_reset_n = 1'b1;
        lexp++;
        repeat (8) @(negedge sys_clk);
        note_misc(1'b0);
        @(negedge sys_clk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk)
    begin
        #2;
        if (pin_q.size() > 0) cmp_pins(pin_q.pop_front(), {pin_oe, pin_out});
        if (misc_q.size() > 0) cmp_misc(misc_q.pop_front(), {gen_in,
            spk_out, ring_out, bus_en, clr, loads});
    end
    always @(posedge sys_clk)
    begin
        if (load_req === 1'b1) loads <= loads + 2'h1;
        cyc++;
        if (cyc == 2000)
        begin
            mismatches++;
            conclude();
        end
    end
    initial
    begin
        void'($urandom(32'hc7122a76));
        repeat (3) @(negedge sys_clk);
        rstn = 1'b1;
        for (int i = 0; i < 60; i++)
        begin
            for (int p = 0; p < 7; p++)
                route_sel[4*p +: 4] = 4'($urandom % 13);
            {general_output, irq_line, host_val} = 19'($urandom);
            src = mft_src_type'(18'($urandom));
            {spk_in, aud_in, ring_sel_pme, ring_indicate, power_event} =
                7'($urandom);
            repeat (5) @(negedge sys_clk);
            for (int p = 0; p < 7; p++)
                if (route_sel[4*p +: 4] == 4'h2 && ok_tab[p][2])
                    gin[gi[p]] = host_val[p];
            note_pins();
            note_misc(1'b0);
            @(negedge sys_clk);
        end
        $display("test random routing done");
        {route_sel, host_val, src, gin} = {28'h0220222, 7'h0, 18'h0, 5'h0};
        repeat (6) @(negedge sys_clk);
        serial_strap = 1'b0;
        global_reset_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        global_reset_n = 1'b1;
        loads = 2'h0;
        bus = 1'b1;
        repeat (6) @(negedge sys_clk);
        note_pins();
        note_misc(1'b0);
        @(negedge sys_clk);
        pulse_pci(1'b1);
        pulse_pci(1'b0);
        $display("test serial bus and suspend done");
        repeat (3) @(negedge sys_clk);
        conclude();
    end
endmodule
`default_nettype wire
